// ---- core/isx_exec.sv ----
/*
 * Execute stage for increment-and-skip, OR literal, move literal and OR with file.
 * Assumes the fetch stage presents one instruction word per cycle with instr_valid,
 * and the file array returns file_rdata combinationally for the address on file_raddr.
 */
`include "isx_regs.svh"
module isx_exec (
    input  wire logic           clk,
    input  wire logic           rst,
    input  wire logic           instr_valid,
    input  wire logic [13:0]    instr,
    output logic      [6:0]     file_raddr,
    input  wire logic [7:0]     file_rdata,
    output logic                file_we,
    output logic      [6:0]     file_waddr,
    output logic      [7:0]     file_wdata,
    output logic      [7:0]     work,
    output logic                zero_flag,
    output logic                skip_busy,
    output logic                done
);
    import isx_pkg::*;

    typedef struct packed {
        logic [7:0] work;
        logic       zero;
        logic       skip;
        logic       we;
        logic [6:0] waddr;
        logic [7:0] wdata;
        logic       done;
    } isx_state_t;

    isx_state_t state_ff;
    isx_state_t nxt_state;
    isx_op_t    op;
    logic [7:0] result;
    logic       to_file;
    logic [7:0] operand;
    logic [7:0] chk_operand;

    // ****************************************
    // Operand bypass
    // ****************************************
    // A file write leaves on a register and lands in the array one edge later.
    // An instruction that reads the same address in that cycle would otherwise see the old value.
    function automatic logic [7:0] isx_fwd(
        input logic       we,
        input logic [6:0] waddr,
        input logic [7:0] wdata,
        input logic [6:0] raddr,
        input logic [7:0] rdata
    );
        return (we && waddr == raddr) ? wdata : rdata;
    endfunction

    isx_decode u_dec (
        .instr (instr),
        .op    (op)
    );

    assign file_raddr = instr[6:0];

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_state.we = 1'b0;
        nxt_state.done = 1'b0;
        nxt_state.skip = 1'b0;
        result = 8'h00;
        to_file = instr[`ISX_DEST_BIT];
        operand = isx_fwd(state_ff.we, state_ff.waddr, state_ff.wdata, instr[6:0], file_rdata);
        if (state_ff.skip) begin
            nxt_state.done = 1'b1;
        end else if (instr_valid) begin
            nxt_state.done = 1'b1;
            case (op)
                ISX_OP_INCSKIP: begin
                    result = operand + 8'h01;
                    nxt_state.skip = (result == 8'h00);
                end
                ISX_OP_ORLIT: begin
                    result = state_ff.work | instr[7:0];
                    to_file = 1'b0;
                    nxt_state.zero = (result == 8'h00);
                end
                ISX_OP_LDLIT: begin
                    result = instr[7:0];
                    to_file = 1'b0;
                end
                ISX_OP_ORFILE: begin
                    result = state_ff.work | operand;
                    nxt_state.zero = (result == 8'h00);
                end
                default: begin
                    nxt_state.done = 1'b0;
                end
            endcase
            if (op != ISX_OP_NONE) begin
                if (to_file) begin
                    nxt_state.we = 1'b1;
                    nxt_state.waddr = instr[6:0];
                    nxt_state.wdata = result;
                end else begin
                    nxt_state.work = result;
                end
            end
        end
    end

    // ****************************************
    // Registers and outputs
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= '{work: `ISX_W_RESET, zero: `ISX_Z_RESET, skip: 1'b0, we: 1'b0,
                          waddr: 7'h00, wdata: 8'h00, done: 1'b0};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign work       = state_ff.work;
    assign zero_flag  = state_ff.zero;
    assign skip_busy  = state_ff.skip;
    assign file_we    = state_ff.we;
    assign file_waddr = state_ff.waddr;
    assign file_wdata = state_ff.wdata;
    assign done       = state_ff.done;

    // ****************************************
    // Checks
    // ****************************************
    assign chk_operand = isx_fwd(file_we, file_waddr, file_wdata, file_raddr, file_rdata);

    property p_inc_sum;
        @(posedge clk) disable iff (rst)
        (instr_valid && !skip_busy && op == ISX_OP_INCSKIP && instr[7])
            |=> (file_we && file_wdata == $past(chk_operand) + 8'h01);
    endproperty
    a_inc_sum: assert property (p_inc_sum) else $error("increment result wrong");

    property p_inc_noflag;
        @(posedge clk) disable iff (rst)
        (instr_valid && !skip_busy && op == ISX_OP_INCSKIP) |=> $stable(zero_flag);
    endproperty
    a_inc_noflag: assert property (p_inc_noflag) else $error("increment touched zero flag");

    property p_skip;
        @(posedge clk) disable iff (rst)
        (instr_valid && !skip_busy && op == ISX_OP_INCSKIP && chk_operand == 8'hFF)
            |=> skip_busy ##1 (!skip_busy && !file_we && $stable(work));
    endproperty
    a_skip: assert property (p_skip) else $error("skip not taken");

    property p_orlit;
        @(posedge clk) disable iff (rst)
        (instr_valid && !skip_busy && op == ISX_OP_ORLIT)
            |=> (work == ($past(work) | $past(instr[7:0])) && zero_flag == (work == 8'h00));
    endproperty
    a_orlit: assert property (p_orlit) else $error("or literal wrong");

    property p_ldlit;
        @(posedge clk) disable iff (rst)
        (instr_valid && !skip_busy && op == ISX_OP_LDLIT)
            |=> (work == $past(instr[7:0]) && $stable(zero_flag) && !file_we);
    endproperty
    a_ldlit: assert property (p_ldlit) else $error("load literal wrong");

    property p_ldlit_dc;
        @(posedge clk) disable iff (rst)
        (instr[13:10] == `ISX_OP4_LDLIT) |-> (op == ISX_OP_LDLIT);
    endproperty
    a_ldlit_dc: assert property (p_ldlit_dc) else $error("load literal rejected");

    property p_orfile;
        @(posedge clk) disable iff (rst)
        (instr_valid && !skip_busy && op == ISX_OP_ORFILE && !instr[7])
            |=> (work == ($past(work) | $past(chk_operand)) && zero_flag == (work == 8'h00));
    endproperty
    a_orfile: assert property (p_orfile) else $error("or file wrong");

    property p_dest;
        @(posedge clk) disable iff (rst)
        (instr_valid && !skip_busy && (op == ISX_OP_INCSKIP || op == ISX_OP_ORFILE))
            |=> (file_we == $past(instr[7]) && (!file_we || file_waddr == $past(instr[6:0])));
    endproperty
    a_dest: assert property (p_dest) else $error("destination select wrong");

    property p_one_cycle;
        @(posedge clk) disable iff (rst)
        (instr_valid && !skip_busy && op != ISX_OP_NONE && !(op == ISX_OP_INCSKIP && chk_operand == 8'hFF))
            |=> (done && !skip_busy);
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("instruction took extra cycle");

    property p_inc_work;
        @(posedge clk) disable iff (rst)
        (instr_valid && !skip_busy && op == ISX_OP_INCSKIP && !instr[7])
            |=> (work == $past(chk_operand) + 8'h01);
    endproperty
    a_inc_work: assert property (p_inc_work) else $error("increment into work wrong");

    property p_unknown;
        @(posedge clk) disable iff (rst)
        (instr_valid && !skip_busy && op == ISX_OP_NONE)
            |=> (!done && !file_we && $stable(work) && $stable(zero_flag));
    endproperty
    a_unknown: assert property (p_unknown) else $error("unknown opcode had an effect");

    c_skip: cover property (@(posedge clk) disable iff (rst) skip_busy);
    c_orlit_zero: cover property (@(posedge clk) disable iff (rst)
        instr_valid && op == ISX_OP_ORLIT ##1 zero_flag);
    c_file_write: cover property (@(posedge clk) disable iff (rst) file_we);
    c_ldlit_dc: cover property (@(posedge clk) disable iff (rst)
        instr_valid && !skip_busy && op == ISX_OP_LDLIT && instr[9:8] != 2'h0);
    c_bypass: cover property (@(posedge clk) disable iff (rst)
        instr_valid && op == ISX_OP_INCSKIP && file_we && file_waddr == file_raddr);
endmodule

// ---- core/isx_regs.svh ----
/*
 * Encoding constants for the four-instruction decode and execute block.
 * Assumes it is included by its bare name by the decode and execute modules.
 */
// What this block does
// - Increment-and-skip adds one to the addressed file register and writes the sum to the destination without touching any flag.
// - When that increment gives zero, the prefetched next instruction is dropped and a no-operation runs in its place, taking two cycles.
// - OR-literal ORs the working register with the literal in bits 7:0, keeps the result in the working register and updates the zero flag.
// - Move-literal loads the literal in bits 7:0 into the working register and changes no flag.
// - OR-with-file ORs the working register with the file register addressed by bits 6:0 and sets the zero flag from the result.
// - For file-operand instructions bit 7 selects the destination: 0 for the working register, 1 for the file register.
`ifndef ISX_REGS_SVH
`define ISX_REGS_SVH
`define ISX_OP6_INCSKIP 6'h0F
`define ISX_OP6_ORLIT   6'h38
`define ISX_OP6_ORFILE  6'h04
`define ISX_OP4_LDLIT   4'hC
`define ISX_DEST_BIT    7
`define ISX_W_RESET     8'h00
`define ISX_Z_RESET     1'h0
`endif

// ---- core/isx_pkg.sv ----
/*
 * Types shared by the decode and execute block.
 * Assumes the encoding header is on the include path.
 */
package isx_pkg;
    typedef enum logic [2:0] {
        ISX_OP_NONE,
        ISX_OP_INCSKIP,
        ISX_OP_ORLIT,
        ISX_OP_LDLIT,
        ISX_OP_ORFILE
    } isx_op_t;
endpackage

// ---- core/isx_decode.sv ----
/*
 * Combinational opcode classifier.
 * Assumes a 14-bit instruction word on its input.
 */
`include "isx_regs.svh"
module isx_decode (
    input  wire logic [13:0]    instr,
    output isx_pkg::isx_op_t    op
);
    import isx_pkg::*;

    always_comb begin
        op = ISX_OP_NONE;
        if (instr[13:8] == `ISX_OP6_INCSKIP) begin
            op = ISX_OP_INCSKIP;
        end else if (instr[13:8] == `ISX_OP6_ORLIT) begin
            op = ISX_OP_ORLIT;
        end else if (instr[13:10] == `ISX_OP4_LDLIT) begin
            op = ISX_OP_LDLIT;
        end else if (instr[13:8] == `ISX_OP6_ORFILE) begin
            op = ISX_OP_ORFILE;
        end
    end
endmodule

// ---- test/isx_file_model.sv ----
/*
 * File register array model on the far side of the execute block.
 * Assumes reads are combinational and writes land on the file_we pulse.
 */
module isx_file_model (
    input  wire logic       clk,
    input  wire logic [6:0] raddr,
    output logic      [7:0] rdata,
    input  wire logic       we,
    input  wire logic [6:0] waddr,
    input  wire logic [7:0] wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:127];
    assign rdata = mem[raddr];
    always @(posedge clk) begin
        if (we === 1'b1) begin
            mem[waddr] <= wdata;
        end
    end
endmodule

// ---- test/incskip_or_movlit_exec_tb.sv ----
/*
 * Self-checking bench for the four-instruction execute block.
 * Assumes the file array model and the design files are compiled first.
 */
`define CHK_EQ(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_total++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module incskip_or_movlit_exec_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        instr_valid = 1'b0;
    logic [13:0] instr = 14'h0000;
    logic [6:0]  file_raddr;
    logic [7:0]  file_rdata;
    logic        file_we;
    logic [6:0]  file_waddr;
    logic [7:0]  file_wdata;
    logic [7:0]  work;
    logic        zero_flag;
    logic        skip_busy;
    logic        done;
    int          err_total = 0;
    int          tests_run = 0;
    int          cycles = 0;
    always #5 clk = ~clk;
    isx_exec dut (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr), .file_raddr(file_raddr),
        .file_rdata(file_rdata), .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata),
        .work(work), .zero_flag(zero_flag), .skip_busy(skip_busy), .done(done));
    isx_file_model fm (.clk(clk), .raddr(file_raddr), .rdata(file_rdata), .we(file_we),
        .waddr(file_waddr), .wdata(file_wdata));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Presents one word at a falling edge and returns at the next falling edge.
    task automatic issue(input logic [13:0] w);
        instr_valid = 1'b1;
        instr = w;
        @(posedge clk);
        @(negedge clk);
    endtask
    task automatic t_reset();
        `CHK_EQ("work", 8'h00, work)
        `CHK_EQ("zero", 1'b0, zero_flag)
        `CHK_EQ("done", 1'b0, done)
    endtask
    task automatic t_orlit();
        issue(14'h309A);
        issue(14'h3835);
        `CHK_EQ("work", 8'hBF, work)
        `CHK_EQ("zero", 1'b0, zero_flag)
        issue(14'h3000);
        issue(14'h3800);
        `CHK_EQ("zero", 1'b1, zero_flag)
        `CHK_EQ("done", 1'b1, done)
    endtask
    task automatic t_ldlit();
        for (int b = 0; b < 4; b++) begin
            issue({4'hC, 2'(b), 8'hA4 + 8'(b)});
            `CHK_EQ("work", 8'hA4 + 8'(b), work)
            `CHK_EQ("zero", 1'b1, zero_flag)
        end
    endtask
    task automatic t_orfile();
        fm.mem[7'h13] = 8'h13;
        fm.mem[7'h20] = 8'h00;
        issue(14'h3091);
        issue({6'h04, 1'b0, 7'h13});
        `CHK_EQ("work", 8'h93, work)
        `CHK_EQ("zero", 1'b0, zero_flag)
        `CHK_EQ("we", 1'b0, file_we)
        issue({6'h04, 1'b1, 7'h13});
        `CHK_EQ("we", 1'b1, file_we)
        `CHK_EQ("waddr", 7'h13, file_waddr)
        `CHK_EQ("wdata", 8'h93, file_wdata)
        issue(14'h3000);
        issue({6'h04, 1'b0, 7'h20});
        `CHK_EQ("zero", 1'b1, zero_flag)
    endtask
    task automatic t_incskip();
        fm.mem[7'h05] = 8'h41;
        fm.mem[7'h06] = 8'hFF;
        issue(14'h3801);
        issue({6'h0F, 1'b1, 7'h05});
        `CHK_EQ("wdata", 8'h42, file_wdata)
        `CHK_EQ("zero", 1'b0, zero_flag)
        `CHK_EQ("skip", 1'b0, skip_busy)
        issue({6'h0F, 1'b0, 7'h05});
        `CHK_EQ("work", 8'h43, work)
        `CHK_EQ("we", 1'b0, file_we)
        issue({6'h0F, 1'b1, 7'h06});
        `CHK_EQ("wdata", 8'h00, file_wdata)
        `CHK_EQ("skip", 1'b1, skip_busy)
        `CHK_EQ("zero", 1'b0, zero_flag)
        issue(14'h3077);
        `CHK_EQ("work", 8'h43, work)
        `CHK_EQ("done", 1'b1, done)
        `CHK_EQ("skip", 1'b0, skip_busy)
        issue(14'h3011);
        `CHK_EQ("work", 8'h11, work)
        issue(14'h2ABC);
        `CHK_EQ("done", 1'b0, done)
        `CHK_EQ("work", 8'h11, work)
    endtask
    // ****************************************
    // Main sequence and timeout
    // ****************************************
    always @(posedge clk) begin
        cycles++;
        if (cycles == 500) begin
            err_total++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_orlit();
        t_ldlit();
        t_orfile();
        t_incskip();
        tally_and_finish();
    end
endmodule
